// [src/acr_pkg.sv]
package acr_pkg;
  localparam logic [7:0] ADDR_FIRST        = 8'h14;
  localparam logic [7:0] ADDR_LAST         = 8'h22;
  localparam logic [7:0] ADDR_SYSTEM_MODE_STATUS     = 8'h14;
  localparam logic [7:0] ADDR_CFG_RANGE    = 8'h15;
  localparam logic [7:0] ADDR_CFG_POWER    = 8'h16;
  localparam logic [7:0] ADDR_CFG_RATE     = 8'h17;
  localparam logic [7:0] ADDR_CFG_INT      = 8'h18;
  localparam logic [7:0] ADDR_CFG_SKIP     = 8'h19;
  localparam logic [7:0] ADDR_WAKE_LO      = 8'h1A;
  localparam logic [7:0] ADDR_WAKE_HI      = 8'h1B;
  localparam logic [7:0] ADDR_SLEEP_LO     = 8'h1C;
  localparam logic [7:0] ADDR_SLEEP_HI     = 8'h1D;
  localparam logic [7:0] ADDR_INACT_LO     = 8'h1E;
  localparam logic [7:0] ADDR_INACT_HI     = 8'h1F;
  localparam logic [7:0] ADDR_INT_EN       = 8'h20;
  localparam logic [7:0] ADDR_INT_ROUTE    = 8'h21;
  localparam logic [7:0] ADDR_OFF_X        = 8'h22;
  // reset values, strap low / strap high
  localparam logic [7:0] RST_SYSTEM_MODE_STATUS_LO   = 8'h00;
  localparam logic [7:0] RST_SYSTEM_MODE_STATUS_HI   = 8'h01;
  localparam logic [7:0] RST_CFG_RANGE_LO  = 8'h00;
  localparam logic [7:0] RST_CFG_RANGE_HI  = 8'h03;
  localparam logic [7:0] RST_CFG_RATE_LO   = 8'h00;
  localparam logic [7:0] RST_CFG_RATE_HI   = 8'hC0;
  localparam logic [7:0] RST_CFG_INT       = 8'h01;
  localparam logic [7:0] RST_INT_EN_LO     = 8'h00;
  localparam logic [7:0] RST_INT_EN_HI     = 8'h20;
  localparam logic [7:0] RST_ZERO          = 8'h00;
  // field positions used by the block's own logic
  localparam int         HI_NIB_W          = 4;
  localparam int         CFG_RANGE_ACTIVE  = 0;
  localparam int         CFG_RANGE_SRST    = 7;
  localparam int         MODE_W            = 2;
  localparam logic [1:0] MODE_STANDBY      = 2'h0;
  localparam logic [1:0] MODE_WAKE         = 2'h1;
  localparam logic [1:0] MODE_SLEEP        = 2'h2;
  localparam int         INACT_W           = 12;
endpackage

// [src/acr_strap_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for an external level
module acr_strap_sync (
  input  wire logic clk_sys,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // no reset: the chain keeps tracking the pin under reset, so the
  // level is already settled at the edge that releases it
  always_ff @(posedge clk_sys) begin
    meta_q <= din;
    dout   <= meta_q; // first stage is read only here
  end
endmodule

// [src/acr_offset_adder.sv]
`timescale 1ns/1ps
// adds the signed zero-g offset to a 12-bit sample, saturating
module acr_offset_adder (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [11:0] raw,
  input  wire logic [7:0]  offset,
  output logic      [11:0] corrected
);
  logic signed [12:0] sum;

  // offset is two's complement, one lsb per lsb of sample
  assign sum = 13'($signed(raw)) + 13'($signed(offset));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      corrected <= 12'h000;
    end else if (sum > 13'sh07FF) begin
      corrected <= 12'h7FF; // clip rather than wrap
    end else if (sum < -13'sh0800) begin
      corrected <= 12'h800;
    end else begin
      corrected <= sum[11:0];
    end
  end
endmodule

// [src/acr_config_bank.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - read-only mode register with gate error fields
// - mode reset 00h strap low, 01h high
// - range/selftest register resets 00h or 03h
// - power/endian register, reset zero
// - rate/decimation register resets 00h or C0h
// - interrupt/trigger register resets to 01h
// - axis skip and hibernate register, reset zero
// - wake idle time 12 bits at 1Ah/1Bh
// - sleep idle time 12 bits at 1Ch/1Dh
// - inactivity count drives automatic sleep entry
// - interrupt enable resets 00h or 20h
// - interrupt pin routing register, reset zero
module acr_config_bank (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        boot_mode_strap,
  input  wire logic        acc_start,
  input  wire logic [7:0]  acc_addr,
  input  wire logic        acc_wr,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic        acc_rd,
  input  wire logic        activity,
  input  wire logic        buf_gate_err,
  input  wire logic [4:0]  buf_gate_cnt,
  input  wire logic [11:0] x_raw,
  output logic      [7:0]  acc_rdata,
  output logic      [7:0]  system_mode_status,
  output logic      [7:0]  sensor_config_range_selftest,
  output logic      [7:0]  sensor_config_power_endian,
  output logic      [7:0]  sensor_config_rate_decimation,
  output logic      [7:0]  sensor_config_interrupt_trigger,
  output logic      [7:0]  sensor_config_axis_skip_hibernate,
  output logic      [11:0] wake_idle_time,
  output logic      [11:0] sleep_idle_time,
  output logic      [7:0]  interrupt_output_enable,
  output logic      [7:0]  interrupt_pin_routing,
  output logic      [11:0] x_corrected
);
  typedef enum logic [1:0] {ST_INIT, ST_RUN} acr_state_type;

  // every check below runs on the system clock, quiet in reset
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  acr_state_type state_q;
  logic        strap_s;
  logic [7:0]  ptr_q;
  logic [7:0]  cur_addr;
  logic        wr_en;
  logic [7:0]  cfg_q [15];
  logic [1:0]  mode_q;
  logic [1:0]  mode_d;
  logic [11:0] inact_q;
  logic [11:0] inact_count;
  logic        auto_sleep_en;
  logic [7:0]  rdata_d;
  logic        in_range;
  logic [3:0]  idx;

  acr_strap_sync u_strap (
    .clk_sys (clk_sys),
    .din     (boot_mode_strap),
    .dout    (strap_s)
  );

  acr_offset_adder u_xoff (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .raw       (x_raw),
    .offset    (cfg_q[14]),
    .corrected (x_corrected)
  );

  // address of the current byte: start address or advancing pointer
  assign cur_addr = acc_start ? acc_addr : ptr_q;
  assign in_range = (cur_addr >= acr_pkg::ADDR_FIRST) &&
                    (cur_addr <= acr_pkg::ADDR_LAST);
  assign idx      = 4'(cur_addr - acr_pkg::ADDR_FIRST);
  // mode register is read-only, writes to it are dropped
  assign wr_en    = acc_wr && in_range &&
                    (cur_addr != acr_pkg::ADDR_SYSTEM_MODE_STATUS);
  assign inact_count = {cfg_q[11][3:0], cfg_q[10]};
  assign auto_sleep_en = (cfg_q[10] != 8'h00);

  // the pointer moves one byte on every access, read or write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ptr_q <= 8'h00;
    end else if (acc_wr || acc_rd) begin
      ptr_q <= cur_addr + 8'h01;
    end
  end

  // strap is caught after reset release, so the registers load once
  // the synchroniser has settled, not under the reset itself
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_INIT;
    end else begin
      state_q <= ST_RUN;
    end
  end

  // configuration storage, index 0 is the mode slot and stays unused
  genvar g;
  generate
    for (g = 1; g < 15; g++) begin : g_reg
      logic [7:0] rst_v;
      if (g == 1) begin : g_r3
        assign rst_v = strap_s ? acr_pkg::RST_CFG_RANGE_HI
                               : acr_pkg::RST_CFG_RANGE_LO;
      end else if (g == 3) begin : g_r5
        assign rst_v = strap_s ? acr_pkg::RST_CFG_RATE_HI
                               : acr_pkg::RST_CFG_RATE_LO;
      end else if (g == 4) begin : g_r6
        assign rst_v = acr_pkg::RST_CFG_INT;
      end else if (g == 12) begin : g_r12
        assign rst_v = strap_s ? acr_pkg::RST_INT_EN_HI
                               : acr_pkg::RST_INT_EN_LO;
      end else begin : g_z
        assign rst_v = acr_pkg::RST_ZERO;
      end
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cfg_q[g] <= acr_pkg::RST_ZERO;
        end else if (state_q == ST_INIT) begin
          cfg_q[g] <= rst_v;
        end else if (g == 1 && cfg_q[1][acr_pkg::CFG_RANGE_SRST]) begin
          cfg_q[g] <= rst_v; // soft reset self-clears next cycle
        end else if (wr_en && idx == 4'(g)) begin
          cfg_q[g] <= acc_wdata;
        end
      end
    end
  endgenerate
  assign cfg_q[0] = 8'h00;

  // operating mode: standby, wake, or auto sleep after inactivity
  always_comb begin
    mode_d = mode_q;
    if (!cfg_q[1][acr_pkg::CFG_RANGE_ACTIVE]) begin
      mode_d = acr_pkg::MODE_STANDBY;
    end else if (activity || !auto_sleep_en) begin
      mode_d = acr_pkg::MODE_WAKE;
    end else if (inact_q >= inact_count) begin
      mode_d = acr_pkg::MODE_SLEEP;
    end else if (mode_q == acr_pkg::MODE_STANDBY) begin
      mode_d = acr_pkg::MODE_WAKE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q  <= acr_pkg::MODE_STANDBY;
      inact_q <= 12'h000;
    end else begin
      mode_q  <= (state_q == ST_INIT) ?
                 (strap_s ? acr_pkg::MODE_WAKE : acr_pkg::MODE_STANDBY)
                 : mode_d;
      if (activity || mode_d != acr_pkg::MODE_WAKE) begin
        inact_q <= 12'h000;
      end else if (inact_q != 12'hFFF) begin
        inact_q <= inact_q + 12'h001;
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (in_range) begin
      rdata_d = (idx == 4'h0) ? system_mode_status : cfg_q[idx];
    end
  end

  // outputs, all registered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_rdata                         <= 8'h00;
      system_mode_status                <= acr_pkg::RST_SYSTEM_MODE_STATUS_LO;
      sensor_config_range_selftest      <= 8'h00;
      sensor_config_power_endian        <= 8'h00;
      sensor_config_rate_decimation     <= 8'h00;
      sensor_config_interrupt_trigger   <= 8'h00;
      sensor_config_axis_skip_hibernate <= 8'h00;
      wake_idle_time                    <= 12'h000;
      sleep_idle_time                   <= 12'h000;
      interrupt_output_enable           <= 8'h00;
      interrupt_pin_routing             <= 8'h00;
    end else begin
      acc_rdata <= acc_rd ? rdata_d : acc_rdata;
      system_mode_status <= {buf_gate_err, buf_gate_cnt, mode_q};
      sensor_config_range_selftest      <= cfg_q[1];
      sensor_config_power_endian        <= cfg_q[2];
      sensor_config_rate_decimation     <= cfg_q[3];
      sensor_config_interrupt_trigger   <= cfg_q[4];
      sensor_config_axis_skip_hibernate <= cfg_q[5];
      wake_idle_time  <= {cfg_q[7][3:0], cfg_q[6]};
      sleep_idle_time <= {cfg_q[9][3:0], cfg_q[8]};
      interrupt_output_enable           <= cfg_q[12];
      interrupt_pin_routing             <= cfg_q[13];
    end
  end

  // access path checks
  // pointer steps one byte past the address just used
  a_ptr_advance: assert property (
    (acc_wr || acc_rd) |=> ptr_q == $past(cur_addr) + 8'h01)
    else $error("address did not advance");

  // the mode slot never turns a write into a store
  a_mode_ro: assert property (
    (state_q == ST_RUN && !acc_start &&
     ptr_q == acr_pkg::ADDR_SYSTEM_MODE_STATUS) |-> !wr_en)
    else $error("mode register took a write");

  // read data is the mux value of the read edge
  a_rdata_value: assert property (
    acc_rd |=> acc_rdata == $past(rdata_d))
    else $error("read data wrong");

  // read data stands until the next read
  a_rdata_hold: assert property (
    !acc_rd |=> $stable(acc_rdata))
    else $error("read data moved without a read");

  // addresses outside the bank read as zero
  a_unmapped_zero: assert property (
    (acc_rd && !in_range) |=> acc_rdata == 8'h00)
    else $error("unmapped read not zero");

  // the mode slot reads the live status byte
  a_mode_read: assert property (
    (acc_rd && in_range && idx == 4'h0) |=>
      acc_rdata == $past(system_mode_status))
    else $error("mode read wrong");

  // status byte packs gate error, gate count and mode
  a_mode_layout: assert property (
    1'b1 |=> system_mode_status ==
      {$past(buf_gate_err), $past(buf_gate_cnt), $past(mode_q)})
    else $error("mode layout wrong");

  // the fourth mode code is never produced
  a_mode_legal: assert property (
    1'b1 |-> mode_q != 2'h3)
    else $error("illegal mode code");

  // reset loading
  // mode after reset follows the strap
  a_mode_strap: assert property (
    (state_q == ST_INIT) |=> mode_q ==
      ($past(strap_s) ? acr_pkg::MODE_WAKE : acr_pkg::MODE_STANDBY))
    else $error("mode reset wrong");

  // range register loads 03h under a high strap
  a_strap_range: assert property (
    (state_q == ST_INIT && strap_s) |=> cfg_q[1] == 8'h03)
    else $error("range reset wrong");

  // rate register loads its strap default
  a_strap_rate: assert property (
    (state_q == ST_INIT) |=> cfg_q[3] == ($past(strap_s) ? 8'hC0 : 8'h00))
    else $error("rate reset wrong");

  // interrupt config loads 01h either way
  a_int_default: assert property (
    (state_q == ST_INIT) |=> cfg_q[4] == 8'h01)
    else $error("interrupt config reset wrong");

  // interrupt enable loads its strap default
  a_int_en_rst: assert property (
    (state_q == ST_INIT) |=> cfg_q[12] == ($past(strap_s) ? 8'h20 : 8'h00))
    else $error("interrupt enable reset wrong");

  // soft reset puts the range register back one cycle later
  a_softrst_clear: assert property (
    (state_q == ST_RUN && cfg_q[1][acr_pkg::CFG_RANGE_SRST]) |=>
      cfg_q[1] == ($past(strap_s) ? 8'h03 : 8'h00))
    else $error("soft reset did not restore");

  // storage and copies
  // a write to the power register lands
  a_power_write: assert property (
    (state_q == ST_RUN && wr_en && idx == 4'h2) |=>
      cfg_q[2] == $past(acc_wdata))
    else $error("power write lost");

  // the power output copies its register
  a_power_copy: assert property (
    1'b1 |=> sensor_config_power_endian == $past(cfg_q[2]))
    else $error("power output wrong");

  // a write to the rate register lands
  a_rate_write: assert property (
    (state_q == ST_RUN && wr_en && idx == 4'h3) |=>
      cfg_q[3] == $past(acc_wdata))
    else $error("rate write lost");

  // a write to the interrupt config lands
  a_int_cfg_write: assert property (
    (state_q == ST_RUN && wr_en && idx == 4'h4) |=>
      cfg_q[4] == $past(acc_wdata))
    else $error("interrupt config write lost");

  // a write to the skip register lands
  a_skip_write: assert property (
    (state_q == ST_RUN && wr_en && idx == 4'h5) |=>
      cfg_q[5] == $past(acc_wdata))
    else $error("skip write lost");

  // wake time joins its two bytes, low byte first
  a_wake_time: assert property (
    1'b1 |=> wake_idle_time == {$past(cfg_q[7][3:0]), $past(cfg_q[6])})
    else $error("wake time mismatch");

  // sleep time joins its two bytes, low byte first
  a_sleep_time: assert property (
    1'b1 |=> sleep_idle_time == {$past(cfg_q[9][3:0]), $past(cfg_q[8])})
    else $error("sleep time mismatch");

  // a write to the interrupt enable lands
  a_int_en_write: assert property (
    (state_q == ST_RUN && wr_en && idx == 4'hC) |=>
      cfg_q[12] == $past(acc_wdata))
    else $error("interrupt enable write lost");

  // routing output copies its register
  a_route_copy: assert property (
    1'b1 |=> interrupt_pin_routing == $past(cfg_q[13]))
    else $error("routing output wrong");

  // operating mode
  // motion restarts the inactivity count
  a_inact_clear: assert property (
    activity |=> inact_q == 12'h000)
    else $error("inactivity count not cleared");

  // a spent count with no motion moves into sleep
  a_sleep_reach: assert property (
    (state_q == ST_RUN && cfg_q[1][acr_pkg::CFG_RANGE_ACTIVE] &&
     auto_sleep_en && !activity && inact_q >= inact_count) |=>
      mode_q == acr_pkg::MODE_SLEEP)
    else $error("sleep not entered");

  // no sleep while the low count is zero
  a_sleep_entry: assert property (
    (state_q == ST_RUN && !auto_sleep_en) |=>
      mode_q != acr_pkg::MODE_SLEEP)
    else $error("sleep without count");

  // standby whenever the active bit is clear
  a_standby_off: assert property (
    (state_q == ST_RUN && !cfg_q[1][acr_pkg::CFG_RANGE_ACTIVE]) |=>
      mode_q == acr_pkg::MODE_STANDBY)
    else $error("not in standby");

endmodule

// [sim/acr_host_model.sv]
`timescale 1ns/1ps
// host side of the access port: one byte request at a time
module acr_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] acc_rdata,
  output logic            acc_start,
  output logic [7:0]      acc_addr,
  output logic            acc_wr,
  output logic [7:0]      acc_wdata,
  output logic            acc_rd
);
  // idle and defined from time zero
  initial begin
    acc_start = 1'b0;
    acc_addr  = 8'h00;
    acc_wr    = 1'b0;
    acc_wdata = 8'h00;
    acc_rd    = 1'b0;
  end

  // request held until the edge that takes it, then released;
  // data is parked at the inverse so a stale byte never looks valid
  task automatic xfer(input logic st, input logic [7:0] a, input logic w,
                      input logic [7:0] d);
    @(posedge clk_sys);
    acc_start <= st;
    acc_addr  <= a;
    acc_wr    <= w;
    acc_wdata <= d;
    acc_rd    <= ~w;
    @(posedge clk_sys);
    acc_start <= 1'b0;
    acc_wr    <= 1'b0;
    acc_wdata <= ~d;
    acc_rd    <= 1'b0;
  endtask

  // single read from an explicit address; sampled a full cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b1, a, 1'b0, 8'h00);
    @(posedge clk_sys);
    #1;
    d = acc_rdata;
  endtask
endmodule

// [sim/test_accel_config_register_bank.sv]
`timescale 1ns/1ps
// drives the register bank through the host model and judges its ports
module test_accel_config_register_bank;
  logic        clk_sys         = 1'b0;
  logic        sys_rst         = 1'b1;
  logic        boot_mode_strap = 1'b0;
  logic        activity        = 1'b1;
  logic        buf_gate_err    = 1'b0;
  logic [4:0]  buf_gate_cnt    = 5'h00;
  logic [11:0] x_raw           = 12'h000;
  logic        acc_start, acc_wr, acc_rd;
  logic [7:0]  acc_addr, acc_wdata, acc_rdata, cfg_range, cfg_rate;
  logic [7:0]  int_en, int_route, mode_st, cfg_pow, cfg_trig, cfg_skip;
  logic [11:0] wake_t, sleep_t, x_corr;
  int          n_fail  = 0;
  int          checked = 0;

  always #25 clk_sys = ~clk_sys;

  acr_host_model acr_host_model_i (.clk_sys(clk_sys), .acc_rdata(acc_rdata),
    .acc_start(acc_start), .acc_addr(acc_addr), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .acc_rd(acc_rd));

  acr_config_bank acr_config_bank_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .boot_mode_strap(boot_mode_strap), .acc_start(acc_start),
    .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
    .acc_rd(acc_rd), .activity(activity), .buf_gate_err(buf_gate_err),
    .buf_gate_cnt(buf_gate_cnt), .x_raw(x_raw), .acc_rdata(acc_rdata),
    .system_mode_status(mode_st), .sensor_config_range_selftest(cfg_range),
    .sensor_config_power_endian(cfg_pow),
    .sensor_config_rate_decimation(cfg_rate),
    .sensor_config_interrupt_trigger(cfg_trig),
    .sensor_config_axis_skip_hibernate(cfg_skip), .wake_idle_time(wake_t),
    .sleep_idle_time(sleep_t), .interrupt_output_enable(int_en),
    .interrupt_pin_routing(int_route), .x_corrected(x_corr));

  task automatic check(input string n, input logic [11:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, e);
    logic [7:0] d;
    acr_host_model_i.rd(a, d);
    check($sformatf("reg %h", a), {4'h0, d}, {4'h0, e});
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // strap settles well before release; first access on the third edge
  task automatic do_reset(input logic s);
    @(posedge clk_sys);
    boot_mode_strap <= s;
    sys_rst         <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // every register read back at its strap-dependent default
  task automatic t_defaults(input logic s);
    logic [7:0] e;
    do_reset(s);
    for (int a = 8'h14; a <= 8'h22; a++) begin
      case (a)
        8'h14:   e = s ? 8'h01 : 8'h00;
        8'h15:   e = s ? 8'h03 : 8'h00;
        8'h17:   e = s ? 8'hC0 : 8'h00;
        8'h18:   e = 8'h01;
        8'h20:   e = s ? 8'h20 : 8'h00;
        default: e = 8'h00;
      endcase
      rdchk(8'(a), e);
    end
    check("rate out", {4'h0, cfg_rate}, s ? 12'h0C0 : 12'h000);
    check("mode out", {4'h0, mode_st}, s ? 12'h001 : 12'h000);
    check("power out", {4'h0, cfg_pow}, 12'h000);
    check("trig out", {4'h0, cfg_trig}, 12'h001);
    check("skip out", {4'h0, cfg_skip}, 12'h000);
  endtask

  // one auto-increment write burst from the unmapped place below the bank to past the end
  task automatic t_rw;
    acr_host_model_i.xfer(1'b1, 8'h13, 1'b1, 8'h03);
    for (int a = 8'h14; a <= 8'h23; a++)
      acr_host_model_i.xfer(1'b0, 8'h00, 1'b1, 8'(a - 8'h10));
    for (int a = 8'h13; a <= 8'h23; a++)
      rdchk(8'(a), (a > 8'h14 && a < 8'h23) ? 8'(a - 8'h10) :
            (a == 8'h14) ? 8'h01 : 8'h00);
    repeat (2) @(posedge clk_sys);
    check("range out", {4'h0, cfg_range}, 12'h005);
    check("wake time", wake_t, 12'hB0A);
    check("sleep time", sleep_t, 12'hD0C);
    check("int enable", {4'h0, int_en}, 12'h010);
    check("int route", {4'h0, int_route}, 12'h011);
    check("power out", {4'h0, cfg_pow}, 12'h006);
    check("rate out", {4'h0, cfg_rate}, 12'h007);
    check("trig out", {4'h0, cfg_trig}, 12'h008);
    check("skip out", {4'h0, cfg_skip}, 12'h009);
  endtask

  // gate error fields show up in the mode register
  task automatic t_status;
    @(posedge clk_sys);
    buf_gate_err <= 1'b1;
    buf_gate_cnt <= 5'h0A;
    rdchk(8'h14, 8'hA9);
    check("mode out", {4'h0, mode_st}, 12'h0A9);
    @(posedge clk_sys);
    buf_gate_err <= 1'b0;
    buf_gate_cnt <= 5'h00;
  endtask

  // offset 12h added to x, including the saturating corner
  task automatic t_offset;
    @(posedge clk_sys);
    x_raw <= 12'h064;
    repeat (3) @(posedge clk_sys);
    check("x plain", x_corr, 12'h076);
    x_raw <= 12'h7F0;
    repeat (3) @(posedge clk_sys);
    check("x clamp", x_corr, 12'h7FF);
  endtask

  // soft reset restores the range register to its strap default
  task automatic t_softrst;
    acr_host_model_i.xfer(1'b1, 8'h15, 1'b1, 8'h85);
    repeat (4) @(posedge clk_sys);
    rdchk(8'h15, 8'h03);
  endtask

  // short inactivity count must carry the mode into sleep, bounded poll
  task automatic t_sleep;
    logic [7:0] d;
    acr_host_model_i.xfer(1'b1, 8'h1F, 1'b1, 8'h00);
    acr_host_model_i.xfer(1'b1, 8'h1E, 1'b1, 8'h03);
    activity <= 1'b0;
    d = 8'h00;
    for (int i = 0; i < 40 && d !== 8'h02; i++)
      acr_host_model_i.rd(8'h14, d);
    check("sleep mode", {4'h0, d}, 12'h002);
  endtask

  // main sequence, then the single verdict
  initial begin
    t_defaults(1'b0);
    t_defaults(1'b1);
    t_rw();
    t_status();
    t_offset();
    t_softrst();
    t_sleep();
    give_verdict();
  end

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #250000;
    n_fail++;
    give_verdict();
  end
endmodule
